// [ipmr_bench.sv]
/*
 * Self-checking bench for ipmr_top over AHB-Lite.
 * Assumes the checker and ipmr_far_model are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ipmr_defs.svh"

module ipmr_bench;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        idle_req, idle_mode, nirq, firq, wake, irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [31:0][3:0] src;
   ipmr_pkg::ipmr_src_grp_t [31:0] set_v, clr_v;
   int          n_fail, num_checks;

   assign hready = hreadyout;
   always #2.5 hclk = ~hclk;

   ipmr_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .src_status(src),
      .idle_mode(idle_mode), .normal_irq(nirq), .fast_interrupt(firq),
      .wake_req(wake), .irq(irq));
   // Line 5 comes out of reset with one status bit set
   ipmr_far_model #(.SRC_RST(128'h0020_0000)) u_far (.hclk(hclk),
      .hresetn(hresetn), .set_v(set_v), .clr_v(clr_v),
      .idle_req(idle_req), .wake_req(wake), .src_status(src),
      .idle_mode(idle_mode));

   // --------------------
   // Tasks
   // --------------------
   task automatic check(input string name, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic rdchk(input string n, input logic [7:0] a,
                        input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(n, rd, exp);
   endtask : rdchk

   task automatic settle;
      repeat (2) @(posedge hclk);
      #1;
   endtask : settle

   task automatic srcop(input int ln, input logic [3:0] s, c);
      @(posedge hclk);
      set_v[ln] <= s;
      clr_v[ln] <= c;
      @(posedge hclk);
      set_v <= '0;
      clr_v <= '0;
      settle();
   endtask : srcop

   task automatic idle_in;
      @(posedge hclk);
      idle_req <= 1'b1;
      @(posedge hclk);
      idle_req <= 1'b0;
      repeat (4) @(posedge hclk);
      #1;
   endtask : idle_in

   task automatic outs(input logic [2:0] e);
      check("normal_fast_wake", {29'h0, nirq, firq, wake}, {29'h0, e});
   endtask : outs

   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   // --------------------
   // Tests
   // --------------------
   initial
   begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {hsel, hwrite, idle_req} = 3'h0;
      htrans = 2'h0;
      hsize = `IPMR_HSIZE_WORD;
      haddr = 32'h0;
      hwdata = 32'h0;
      set_v = '0;
      clr_v = '0;
      n_fail = 0;
      num_checks = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk("ctrl", `IPMR_OFS_CTRL, 32'h0);
      rdchk("evt_mask", `IPMR_OFS_EVT_MSK, 32'h0);
      rdchk("unmapped", 8'h20, 32'h0);
      $display("test reset values done");
      bus(1'b1, `IPMR_OFS_MASK, 32'h0);
      bus(1'b1, `IPMR_OFS_LEVEL, 32'h8000_2000);
      rdchk("level", `IPMR_OFS_LEVEL, 32'h8000_2000);
      bus(1'b1, `IPMR_OFS_NORMAL, 32'hffff_ffff);
      rdchk("normal_view", `IPMR_OFS_NORMAL, 32'h20);
      settle();
      outs(3'b000);
      $display("test masked reset pending done");
      bus(1'b1, `IPMR_OFS_MASK, 32'hffff_ffff);
      rdchk("mask", `IPMR_OFS_MASK, 32'hffff_ffff);
      settle();
      outs(3'b101);
      srcop(31, 4'h8, 4'h0);
      outs(3'b111);
      srcop(13, 4'h1, 4'h0);
      rdchk("fast_view", `IPMR_OFS_FAST, 32'h8000_2000);
      srcop(5, 4'h4, 4'h0);
      srcop(5, 4'h0, 4'h2);
      rdchk("normal_view", `IPMR_OFS_NORMAL, 32'h20);
      srcop(5, 4'h0, 4'h4);
      rdchk("normal_view", `IPMR_OFS_NORMAL, 32'h0);
      outs(3'b011);
      srcop(31, 4'h0, 4'h8);
      srcop(13, 4'h0, 4'h1);
      outs(3'b000);
      $display("test routing and clearing done");
      bus(1'b1, `IPMR_OFS_MASK, 32'hffff_fffe);
      srcop(0, 4'h1, 4'h0);
      outs(3'b000);
      rdchk("normal_view", `IPMR_OFS_NORMAL, 32'h1);
      bus(1'b1, `IPMR_OFS_LEVEL, 32'h1);
      settle();
      outs(3'b000);
      rdchk("fast_view", `IPMR_OFS_FAST, 32'h1);
      $display("test masking done");
      idle_in();
      check("idle_mode", idle_mode, 32'h0);
      bus(1'b1, `IPMR_OFS_CTRL, 32'h1);
      idle_in();
      check("idle_mode", idle_mode, 32'h1);
      bus(1'b1, `IPMR_OFS_MASK, 32'hffff_ffff);
      settle();
      check("idle_mode", idle_mode, 32'h0);
      bus(1'b1, `IPMR_OFS_CTRL, 32'h0);
      $display("test idle mode done");
      bus(1'b1, `IPMR_OFS_EVT_MSK, 32'h7);
      rdchk("evt_status", `IPMR_OFS_EVT_STS, 32'h7);
      check("irq", {31'h0, irq}, 32'h1);
      bus(1'b1, `IPMR_OFS_EVT_STS, 32'h0);
      rdchk("evt_status", `IPMR_OFS_EVT_STS, 32'h7);
      bus(1'b1, `IPMR_OFS_EVT_STS, 32'h7);
      rdchk("evt_status", `IPMR_OFS_EVT_STS, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      bus(1'b1, `IPMR_OFS_EVT_MSK, 32'h0);
      srcop(0, 4'h0, 4'h1);
      srcop(0, 4'h1, 4'h0);
      rdchk("evt_status", `IPMR_OFS_EVT_STS, 32'h6);
      check("irq", {31'h0, irq}, 32'h0);
      $display("test event interrupt done");
      end_of_test();
   end

   // Whole run is well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge hclk);
      n_fail++;
      end_of_test();
   end
endmodule : ipmr_bench
`default_nettype wire

// [ipmr_defs.svh]
/*
 * Constants of the interrupt pending, mask and route block: register
 * byte offsets, field positions, reset values and widths.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef IPMR_DEFS_SVH
`define IPMR_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define IPMR_LINES        32
`define IPMR_L2_W         4
`define IPMR_DATA_W       32
`define IPMR_ADDR_W       32
`define IPMR_OFS_W        8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IPMR_OFS_NORMAL   8'h00
`define IPMR_OFS_MASK     8'h04
`define IPMR_OFS_LEVEL    8'h08
`define IPMR_OFS_CTRL     8'h0c
`define IPMR_OFS_FAST     8'h10
`define IPMR_OFS_EVT_STS  8'h30
`define IPMR_OFS_EVT_MSK  8'h34

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define IPMR_CTRL_DIM_BIT 0
`define IPMR_EVT_W        3
`define IPMR_EVT_NORMAL   0
`define IPMR_EVT_FAST     1
`define IPMR_EVT_WAKE     2
`define IPMR_CTRL_RST     1'b0
`define IPMR_EVT_RST      3'h0
`define IPMR_HTRANS_NSEQ  2'h2
`define IPMR_HSIZE_WORD   3'h2

`endif

// [ipmr_far_model.sv]
/*
 * Source units with write-one-to-clear status, and the power manager.
 * Assumes the bench pulses set_v, clr_v and idle_req for one cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module ipmr_far_model
#(
   parameter logic [127:0] SRC_RST = 128'h0
)
(
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Bench stimulus
   input  wire logic [31:0][3:0] set_v,
   input  wire logic [31:0][3:0] clr_v,
   input  wire logic             idle_req,
   // From the controller
   input  wire logic             wake_req,
   // To the controller
   output logic [31:0][3:0]      src_status,
   output logic                  idle_mode
);
   ipmr_pkg::ipmr_src_grp_t [31:0] src_q, src_d;
   logic                           idle_q, idle_d;

   always_comb
   begin
      // Only ones clear; a new event wins over a clear
      src_d = (src_q & ~clr_v) | set_v;
      // A wake request ends idle; an idle_req in the same cycle wins over it
      idle_d = idle_req | (idle_q & ~wake_req);
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         src_q  <= SRC_RST;
         idle_q <= 1'b0;
      end
      else
      begin
         src_q  <= src_d;
         idle_q <= idle_d;
      end
   end
   assign src_status = src_q;
   assign idle_mode  = idle_q;
endmodule : ipmr_far_model
`default_nettype wire

// [ipmr_line_gate.sv]
/*
 * One interrupt line: ORs the second-level status bits into the pending
 * flag, gates it with the effective mask and steers it by the route bit.
 * Assumes purely combinational use inside the controller top.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ipmr_defs.svh"

module ipmr_line_gate
#(
   parameter int W = `IPMR_L2_W
)
(
   // Source unit status
   input  wire logic [W-1:0] status,
   // Steering
   input  wire logic         mask_eff,
   input  wire logic         route,
   // Views and outputs
   output logic              pending,
   output logic              normal_view,
   output logic              fast_view,
   output logic              normal_req,
   output logic              fast_req
);

   // No storage here, so the flag tracks the source from reset onward
   assign pending     = |status;
   assign normal_view = pending & ~route;
   assign fast_view   = pending & route;
   // Masked lines leave both inputs alone, route bit ignored
   assign normal_req  = pending & mask_eff & ~route;
   assign fast_req    = pending & mask_eff & route;

endmodule : ipmr_line_gate

`default_nettype wire

// [ipmr_pkg.sv]
/*
 * Types of the interrupt pending, mask and route block.
 * Assumes ipmr_defs.svh is on the include path.
 */
`include "ipmr_defs.svh"

package ipmr_pkg;

   // Second-level status bits of one line, as held by its source unit
   typedef logic [`IPMR_L2_W-1:0] ipmr_src_grp_t;

   // Captured AHB address phase
   typedef struct packed {
      logic                   valid;
      logic                   write;
      logic [`IPMR_OFS_W-1:0] ofs;
   } ipmr_aphase_t;

   // Bus slave sequencing
   typedef enum logic [0:0] {
      IPMR_BUS_IDLE,
      IPMR_BUS_RD_WAIT
   } ipmr_bus_state_t;

endpackage : ipmr_pkg

// [ipmr_top.sv]
/*
 * First-level interrupt controller with an AHB-Lite register slave.
 * Collects 32 lines from source units, shows normal and fast pending
 * views, masks and routes them to the core's two interrupt inputs and
 * drives a wake request to the power manager.
 * Assumes source units hold their own write-one-to-clear status bits and
 * present them on src_status; idle_mode comes from the power manager;
 * all inputs are synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ipmr_defs.svh"

// Summary of operation
// - Thirty-two pending flags in both the normal and the fast views.
// - Each pending flag is read-only, the OR of its line's status bits.
// - Clearing a source status bit drops the flag if none other remains.
// - Status bits clear only on a written one; zero leaves them alone.
// - Pending flags reset to the OR of source status reset states.
// - One mask bit for each of the 32 lines.
// - Outside idle, a line reaches core and power manager only if unmasked.
// - In idle, unless the disable bit is set, masks are ignored and every request becomes active.
// - Masking never hides the pending flag from software.
// - Mask bits are not reset and stay unknown until written.
// - Route bit zero picks the normal input, one picks the fast input.
// - A masked line's route bit affects neither core input.
// - Route bits are not reset; software programs them first.
// - Normal view shows normal-routed lines, fast view fast-routed ones.
// - Idle-mask-disable bit, reset to zero, makes idle wake obey masks.
module ipmr_top
(
   // Clock and reset
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   // AHB-Lite slave
   input  wire logic                         hsel,
   input  wire logic [`IPMR_ADDR_W-1:0]      haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [`IPMR_DATA_W-1:0]      hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic [`IPMR_DATA_W-1:0]           hrdata,
   // Source units and power manager
   input  wire ipmr_pkg::ipmr_src_grp_t [`IPMR_LINES-1:0] src_status,
   input  wire logic                         idle_mode,
   // Core and power manager requests
   output logic                              normal_irq,
   output logic                              fast_interrupt,
   output logic                              wake_req,
   // Block event interrupt
   output logic                              irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   ipmr_pkg::ipmr_bus_state_t bus_state_q;
   ipmr_pkg::ipmr_bus_state_t bus_state_d;
   ipmr_pkg::ipmr_aphase_t    aph_q;
   ipmr_pkg::ipmr_aphase_t    aph_d;
   logic                      hreadyout_q;
   logic                      hreadyout_d;
   logic [`IPMR_DATA_W-1:0]   hrdata_q;
   logic [`IPMR_DATA_W-1:0]   hrdata_d;

   logic [`IPMR_LINES-1:0]    interrupt_mask_q;
   logic [`IPMR_LINES-1:0]    interrupt_mask_d;
   logic [`IPMR_LINES-1:0]    interrupt_routing_level_q;
   logic [`IPMR_LINES-1:0]    interrupt_routing_level_d;
   logic                      mask_written_q;
   logic                      mask_written_d;
   logic                      level_written_q;
   logic                      level_written_d;
   logic                      idle_mask_disable_q;
   logic                      idle_mask_disable_d;

   logic [`IPMR_EVT_W-1:0]    evt_sts_q;
   logic [`IPMR_EVT_W-1:0]    evt_sts_d;
   logic [`IPMR_EVT_W-1:0]    evt_msk_q;
   logic [`IPMR_EVT_W-1:0]    evt_msk_d;
   logic [`IPMR_EVT_W-1:0]    evt_set;

   logic                      normal_irq_q;
   logic                      normal_irq_d;
   logic                      fast_interrupt_q;
   logic                      fast_interrupt_d;
   logic                      wake_req_q;
   logic                      wake_req_d;
   logic                      irq_q;
   logic                      irq_d;

   logic [`IPMR_LINES-1:0]    pending;
   logic [`IPMR_LINES-1:0]    normal_request_pending;
   logic [`IPMR_LINES-1:0]    fast_request_pending;
   logic [`IPMR_LINES-1:0]    normal_line;
   logic [`IPMR_LINES-1:0]    fast_line;
   logic [`IPMR_LINES-1:0]    mask_eff;
   logic                      masks_ignored;
   logic                      addr_take;
   logic                      wr_commit;

   // ----------------------------------------------------------------------
   // Line gating
   // ----------------------------------------------------------------------
   // In idle the mask is forced to all ones unless the disable bit is set
   assign masks_ignored = idle_mode & ~idle_mask_disable_q;

   always_comb
   begin
      if (masks_ignored)
      begin
         mask_eff = '1;
      end
      else if (mask_written_q)
      begin
         mask_eff = interrupt_mask_q;
      end
      else
      begin
         // Mask content unknown until written: keep the outputs quiet
         mask_eff = '0;
      end
   end

   generate
      for (genvar i = 0; i < `IPMR_LINES; i++)
      begin : g_line
         ipmr_line_gate #(
            .W (`IPMR_L2_W)
         ) u_gate (
            .status      (src_status[i]),
            .mask_eff    (mask_eff[i]),
            .route       (interrupt_routing_level_q[i]),
            .pending     (pending[i]),
            .normal_view (normal_request_pending[i]),
            .fast_view   (fast_request_pending[i]),
            .normal_req  (normal_line[i]),
            .fast_req    (fast_line[i])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Core and power manager requests
   // ----------------------------------------------------------------------
   always_comb
   begin
      // Route bits unknown until written, so routed outputs wait for them
      normal_irq_d     = level_written_q & (|normal_line);
      fast_interrupt_d = level_written_q & (|fast_line);
      // Wake does not depend on routing, only on the effective mask
      wake_req_d       = |(pending & mask_eff);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         normal_irq_q     <= 1'b0;
         fast_interrupt_q <= 1'b0;
         wake_req_q       <= 1'b0;
      end
      else
      begin
         normal_irq_q     <= normal_irq_d;
         fast_interrupt_q <= fast_interrupt_d;
         wake_req_q       <= wake_req_d;
      end
   end

   // ----------------------------------------------------------------------
   // AHB-Lite address phase and read wait state
   // ----------------------------------------------------------------------
   assign addr_take = hsel & hready & htrans[1];
   assign wr_commit = aph_q.valid & aph_q.write;

   always_comb
   begin
      bus_state_d = bus_state_q;
      aph_d       = aph_q;
      hreadyout_d = hreadyout_q;
      hrdata_d    = hrdata_q;
      unique case (bus_state_q)
         ipmr_pkg::IPMR_BUS_IDLE:
         begin
            aph_d.valid = addr_take;
            aph_d.write = hwrite;
            aph_d.ofs   = haddr[`IPMR_OFS_W-1:0];
            if (addr_take && !hwrite)
            begin
               // One wait state lets a write in flight land before the read
               hreadyout_d = 1'b0;
               bus_state_d = ipmr_pkg::IPMR_BUS_RD_WAIT;
            end
         end
         ipmr_pkg::IPMR_BUS_RD_WAIT:
         begin
            aph_d.valid = 1'b0;
            hreadyout_d = 1'b1;
            bus_state_d = ipmr_pkg::IPMR_BUS_IDLE;
            unique case (aph_q.ofs)
               `IPMR_OFS_NORMAL: hrdata_d = normal_request_pending;
               `IPMR_OFS_FAST:   hrdata_d = fast_request_pending;
               `IPMR_OFS_MASK:   hrdata_d = interrupt_mask_q;
               `IPMR_OFS_LEVEL:  hrdata_d = interrupt_routing_level_q;
               `IPMR_OFS_CTRL:   hrdata_d = {31'h0, idle_mask_disable_q};
               `IPMR_OFS_EVT_STS: hrdata_d = {29'h0, evt_sts_q};
               `IPMR_OFS_EVT_MSK: hrdata_d = {29'h0, evt_msk_q};
               default:          hrdata_d = 32'h0;
            endcase
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_state_q <= ipmr_pkg::IPMR_BUS_IDLE;
         aph_q       <= '0;
         hreadyout_q <= 1'b1;
         hrdata_q    <= 32'h0;
      end
      else
      begin
         bus_state_q <= bus_state_d;
         aph_q       <= aph_d;
         hreadyout_q <= hreadyout_d;
         hrdata_q    <= hrdata_d;
      end
   end

   // ----------------------------------------------------------------------
   // Mask and route registers
   // ----------------------------------------------------------------------
   // Pending views are computed, never written: writes to them are dropped
   always_comb
   begin
      interrupt_mask_d          = interrupt_mask_q;
      interrupt_routing_level_d = interrupt_routing_level_q;
      if (wr_commit && aph_q.ofs == `IPMR_OFS_MASK)
      begin
         interrupt_mask_d = hwdata;
      end
      if (wr_commit && aph_q.ofs == `IPMR_OFS_LEVEL)
      begin
         interrupt_routing_level_d = hwdata;
      end
   end

   // No reset on purpose: contents stay whatever they were until written
   always_ff @(posedge hclk)
   begin
      interrupt_mask_q          <= interrupt_mask_d;
      interrupt_routing_level_q <= interrupt_routing_level_d;
   end

   // ----------------------------------------------------------------------
   // Control register and written flags
   // ----------------------------------------------------------------------
   always_comb
   begin
      idle_mask_disable_d = idle_mask_disable_q;
      mask_written_d      = mask_written_q;
      level_written_d     = level_written_q;
      if (wr_commit && aph_q.ofs == `IPMR_OFS_CTRL)
      begin
         idle_mask_disable_d = hwdata[`IPMR_CTRL_DIM_BIT];
      end
      if (wr_commit && aph_q.ofs == `IPMR_OFS_MASK)
      begin
         mask_written_d = 1'b1;
      end
      if (wr_commit && aph_q.ofs == `IPMR_OFS_LEVEL)
      begin
         level_written_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         idle_mask_disable_q <= `IPMR_CTRL_RST;
         mask_written_q      <= 1'b0;
         level_written_q     <= 1'b0;
      end
      else
      begin
         idle_mask_disable_q <= idle_mask_disable_d;
         mask_written_q      <= mask_written_d;
         level_written_q     <= level_written_d;
      end
   end

   // ----------------------------------------------------------------------
   // Block events and interrupt
   // ----------------------------------------------------------------------
   // Events are rising edges of the registered requests
   always_comb
   begin
      evt_set                  = '0;
      evt_set[`IPMR_EVT_NORMAL] = normal_irq_d & ~normal_irq_q;
      evt_set[`IPMR_EVT_FAST]   = fast_interrupt_d & ~fast_interrupt_q;
      evt_set[`IPMR_EVT_WAKE]   = wake_req_d & ~wake_req_q;
   end

   always_comb
   begin
      evt_sts_d = evt_sts_q;
      evt_msk_d = evt_msk_q;
      if (wr_commit && aph_q.ofs == `IPMR_OFS_EVT_STS)
      begin
         // Ones clear, zeros leave the bit alone
         evt_sts_d = evt_sts_q & ~hwdata[`IPMR_EVT_W-1:0];
      end
      // A new event in the clearing cycle survives the clear
      evt_sts_d = evt_sts_d | evt_set;
      if (wr_commit && aph_q.ofs == `IPMR_OFS_EVT_MSK)
      begin
         evt_msk_d = hwdata[`IPMR_EVT_W-1:0];
      end
      irq_d = |(evt_sts_d & evt_msk_d);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         evt_sts_q <= `IPMR_EVT_RST;
         evt_msk_q <= `IPMR_EVT_RST;
         irq_q     <= 1'b0;
      end
      else
      begin
         evt_sts_q <= evt_sts_d;
         evt_msk_q <= evt_msk_d;
         irq_q     <= irq_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign hreadyout      = hreadyout_q;
   assign hresp          = 1'b0;
   assign hrdata         = hrdata_q;
   assign normal_irq     = normal_irq_q;
   assign fast_interrupt = fast_interrupt_q;
   assign wake_req       = wake_req_q;
   assign irq            = irq_q;

endmodule : ipmr_top

`default_nettype wire

// [ipmr_top_asserts.sv]
/*
 * Port-level assertions for ipmr_top, bound to it at the foot of the file.
 * Assumes one AHB-Lite slave, with hready tied to hreadyout.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ipmr_defs.svh"

module ipmr_top_asserts
(
   // Clock and reset
   input wire logic             hclk,
   input wire logic             hresetn,
   // AHB-Lite slave
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [2:0]       hsize,
   input wire logic [31:0]      hwdata,
   input wire logic             hready,
   input wire logic             hreadyout,
   input wire logic             hresp,
   input wire logic [31:0]      hrdata,
   // Source units and power manager
   input wire logic [31:0][3:0] src_status,
   input wire logic             idle_mode,
   // Requests
   input wire logic             normal_irq,
   input wire logic             fast_interrupt,
   input wire logic             wake_req,
   input wire logic             irq
);
   logic        ap_v_q, ap_w_q, dim_q, msk_w_q, lvl_w_q, taken, wdone;
   logic [7:0]  ap_ofs_q;
   logic [31:0] msk_q, lvl_q, pend, eff, v_n, v_f;
   logic        armed, e_n, e_f, e_w, blk, idl_any, dim_blk;

   // --------------------
   // Shadow of what software wrote
   // --------------------
   assign taken = hsel & hready & htrans[1];
   assign wdone = ap_v_q & ap_w_q & hreadyout;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_v_q  <= 1'b0;
         ap_w_q  <= 1'b0;
         dim_q   <= 1'b0;
         msk_w_q <= 1'b0;
         lvl_w_q <= 1'b0;
      end
      else
      begin
         if (wdone && ap_ofs_q == `IPMR_OFS_MASK)
            msk_w_q <= 1'b1;
         if (wdone && ap_ofs_q == `IPMR_OFS_LEVEL)
            lvl_w_q <= 1'b1;
         if (wdone && ap_ofs_q == `IPMR_OFS_CTRL)
            dim_q <= hwdata[0];
         if (taken)
            ap_v_q <= 1'b1;
         else if (hreadyout)
            ap_v_q <= 1'b0;
         if (taken)
            ap_w_q <= hwrite;
      end
   end
   // Mask and level carry no reset, as in the block itself
   always_ff @(posedge hclk)
   begin
      if (taken)
         ap_ofs_q <= haddr[7:0];
      if (wdone && ap_ofs_q == `IPMR_OFS_MASK)
         msk_q <= hwdata;
      if (wdone && ap_ofs_q == `IPMR_OFS_LEVEL)
         lvl_q <= hwdata;
   end
   always_comb
   begin
      for (int i = 0; i < 32; i++)
         pend[i] = |src_status[i];
      eff = (idle_mode && !dim_q) ? 32'hffff_ffff : msk_q;
      v_n = pend & ~lvl_q;
      v_f = pend & lvl_q;
      e_n = |(pend & eff & ~lvl_q);
      e_f = |(pend & eff & lvl_q);
      e_w = |(pend & eff);
      armed = msk_w_q & lvl_w_q;
      blk = armed & ~idle_mode & ~|(pend & msk_q);
      idl_any = idle_mode & ~dim_q & |pend;
      dim_blk = msk_w_q & idle_mode & dim_q & ~|(pend & msk_q);
   end

   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_NORMAL_OUT: assert property
      ($past(armed) |-> normal_irq == $past(e_n))
      else $error("normal_irq differs from routed lines");
   AST_FAST_OUT: assert property
      ($past(armed) |-> fast_interrupt == $past(e_f))
      else $error("fast_interrupt differs from routed lines");
   AST_MASK_BLOCK: assert property
      ($past(blk) |-> !normal_irq && !fast_interrupt)
      else $error("masked line reached the core");
   AST_IDLE_WAKE: assert property
      ($past(idl_any) |-> wake_req)
      else $error("idle request did not wake");
   AST_DIM_HOLD: assert property
      ($past(dim_blk) |-> !wake_req)
      else $error("masked line woke with mask disable set");
   AST_WAKE_OUT: assert property
      ($past(msk_w_q) |-> wake_req == $past(e_w))
      else $error("wake_req differs from effective lines");
   AST_CORE_WAKE: assert property
      (normal_irq || fast_interrupt |-> wake_req)
      else $error("core request without wake request");
   AST_NORMAL_VIEW: assert property
      (taken && !hwrite && haddr[7:0] == `IPMR_OFS_NORMAL && lvl_w_q
       |-> ##2 hrdata == $past(v_n))
      else $error("normal view read wrong");
   AST_FAST_VIEW: assert property
      (taken && !hwrite && haddr[7:0] == `IPMR_OFS_FAST && lvl_w_q
       |-> ##2 hrdata == $past(v_f))
      else $error("fast view read wrong");
   AST_READ_WAIT: assert property
      (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WRITE_NOWAIT: assert property
      (taken && hwrite |=> hreadyout)
      else $error("write stalled");
   AST_OKAY: assert property (hresp == 1'b0)
      else $error("response not OKAY");
endmodule : ipmr_top_asserts

bind ipmr_top ipmr_top_asserts u_asserts (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .src_status(src_status),
   .idle_mode(idle_mode), .normal_irq(normal_irq),
   .fast_interrupt(fast_interrupt), .wake_req(wake_req), .irq(irq));
`default_nettype wire
